// ### rcr_pkg.sv
package rcr_pkg;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned REG_W  = 8;
   localparam int unsigned MIN_ADDR_W = 10;

   // register indices, channel order three, four, five, six
   // the bus byte address is four times the index
   localparam logic [3:0][7:0] VSEL_IDX = {8'h60, 8'h50, 8'h40, 8'h30};
   localparam logic [3:0][7:0] CTRL_IDX = {8'h61, 8'h51, 8'h41, 8'h32};
   localparam logic [7:0] IRQ_STATUS_IDX = 8'hF0;
   localparam logic [7:0] IRQ_MASK_IDX   = 8'hF1;

   // control field positions
   localparam int unsigned ON_BIT     = 7;
   localparam int unsigned OPT_BIT    = 2;
   localparam int unsigned UNMASK_BIT = 1;
   localparam int unsigned PGOOD_BIT  = 0;

   // channel shapes, bit k belongs to channel index k
   localparam logic [3:0] WIDE_CODE  = 4'h2;
   localparam logic [3:0] HAS_PHASE  = 4'h1;
   localparam logic [3:0] HAS_DISCH  = 4'hC;
   localparam logic [3:0] HAS_UNMASK = 4'hD;
   localparam int unsigned NARROW_CODE_W = 6;
   localparam int unsigned WIDE_CODE_W   = 8;

   // reset values
   localparam logic [7:0] RST_CODE     = 8'h00;
   localparam logic       RST_ON       = 1'h0;
   localparam logic       RST_OPT      = 1'h0;
   localparam logic       RST_UNMASK   = 1'h0;
   localparam logic [3:0] RST_IRQ_MASK = 4'h0;
endpackage : rcr_pkg

// ### rcr_chan.sv
`timescale 1ns/1ns
`default_nettype none
module rcr_chan #(
   parameter int unsigned CODE_W     = 6,
   parameter bit          HAS_OPT    = 1'h1,
   parameter bit          HAS_UNMASK = 1'h1
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       vsel_we,
   input  wire logic       ctrl_we,
   input  wire logic [7:0] wdata,
   input  wire logic       pgood,
   output logic      [7:0] code_ff,
   output logic            on_ff,
   output logic            opt_ff,
   output logic            unmask_ff,
   output logic      [7:0] vsel_rd,
   output logic      [7:0] ctrl_rd
);
   localparam logic [7:0] CODE_MASK = 8'((9'h001 << CODE_W) - 9'h001);

   if (CODE_W < 1 || CODE_W > rcr_pkg::REG_W) begin : g_bad_width
      $error("rcr_chan: code width out of range");
   end

   // upper reserved bits never store, so they read zero
   always_ff @(posedge clk) begin
      if (rst) code_ff <= rcr_pkg::RST_CODE & CODE_MASK;
      else if (vsel_we) code_ff <= wdata & CODE_MASK;
   end

   // enable bit, stored and read back as written
   always_ff @(posedge clk) begin
      if (rst) on_ff <= rcr_pkg::RST_ON;
      else if (ctrl_we) on_ff <= wdata[rcr_pkg::ON_BIT];
   end

   // bit 2 is phase or discharge, absent on the boost channel
   if (HAS_OPT) begin : g_opt
      always_ff @(posedge clk) begin
         if (rst) opt_ff <= rcr_pkg::RST_OPT;
         else if (ctrl_we) opt_ff <= wdata[rcr_pkg::OPT_BIT];
      end
   end else begin : g_no_opt
      assign opt_ff = 1'h0;
   end

   if (HAS_UNMASK) begin : g_unmask
      always_ff @(posedge clk) begin
         if (rst) unmask_ff <= rcr_pkg::RST_UNMASK;
         else if (ctrl_we) unmask_ff <= wdata[rcr_pkg::UNMASK_BIT];
      end
   end else begin : g_no_unmask
      assign unmask_ff = 1'h0;
   end

   // readback; power-good is live, reserved bits are zero
   always_comb begin
      vsel_rd = code_ff;
      ctrl_rd = 8'h00;
      ctrl_rd[rcr_pkg::ON_BIT]     = on_ff;
      ctrl_rd[rcr_pkg::OPT_BIT]    = opt_ff;
      ctrl_rd[rcr_pkg::UNMASK_BIT] = unmask_ff;
      ctrl_rd[rcr_pkg::PGOOD_BIT]  = pgood;
   end
endmodule : rcr_chan
`default_nettype wire

// ### rcr_irq.sv
`timescale 1ns/1ns
`default_nettype none
module rcr_irq #(
   parameter int unsigned N = 4
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [N-1:0] evt,
   input  wire logic         clr_we,
   input  wire logic         mask_we,
   input  wire logic [N-1:0] wdata,
   output logic      [N-1:0] status_ff,
   output logic      [N-1:0] mask_ff,
   output logic              irq_ff
);
   logic [N-1:0] nxt_status;
   logic [N-1:0] nxt_mask;

   if (N < 1 || N > rcr_pkg::REG_W) begin : g_bad_n
      $error("rcr_irq: event count out of range");
   end

   // write one clears; a same-cycle event wins over the clear
   always_comb begin
      nxt_status = (status_ff & ~(clr_we ? wdata : '0)) | evt;
      nxt_mask   = mask_we ? wdata : mask_ff;
   end

   always_ff @(posedge clk) begin
      if (rst) status_ff <= '0;
      else status_ff <= nxt_status;
   end

   always_ff @(posedge clk) begin
      if (rst) mask_ff <= N'(rcr_pkg::RST_IRQ_MASK);
      else mask_ff <= nxt_mask;
   end

   // computed from next values so irq tracks status with no lag
   always_ff @(posedge clk) begin
      if (rst) irq_ff <= 1'h0;
      else irq_ff <= |(nxt_status & nxt_mask);
   end
endmodule : rcr_irq
`default_nettype wire

// ### rcr_regs.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rcr_regs #(
   parameter int unsigned ADDR_W = 10
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic       [31:0] pwdata,
   input  wire logic        [3:0] pstrb,
   output logic            [31:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic        [3:0] power_good,
   input  wire logic        [3:0] channel_fault,
   output logic             [3:0] regulator_on,
   output logic             [5:0] channel_three_code,
   output logic             [7:0] channel_four_code,
   output logic             [5:0] channel_five_code,
   output logic             [5:0] channel_six_code,
   output logic                   channel_three_phase,
   output logic                   channel_five_discharge,
   output logic                   channel_six_discharge,
   output logic                   irq
);
   localparam int unsigned NCH = rcr_pkg::NUM_CH;

   if (ADDR_W < rcr_pkg::MIN_ADDR_W || ADDR_W > 32) begin : g_bad_addr
      $error("rcr_regs: address width cannot reach the map");
   end

   // exact word match; unaligned or high addresses miss
   function automatic logic f_hit(
      input logic [ADDR_W-1:0] a,
      input logic [7:0]        idx
   );
      return a == ADDR_W'({idx, 2'h0});
   endfunction : f_hit

   logic             pready_ff;
   logic             pslverr_ff;
   logic      [31:0] prdata_ff;
   logic             setup;
   logic             take;
   logic             wr_en;
   logic [NCH-1:0]   hit_vsel;
   logic [NCH-1:0]   hit_ctrl;
   logic             hit_stat;
   logic             hit_mask;
   logic             map_hit;
   logic       [7:0] rd_byte;
   logic       [7:0] code_w   [NCH];
   logic       [7:0] vsel_rd  [NCH];
   logic       [7:0] ctrl_rd  [NCH];
   logic [NCH-1:0]   on_w;
   logic [NCH-1:0]   opt_w;
   logic [NCH-1:0]   unmask_w;
   logic [NCH-1:0]   evt;
   logic [NCH-1:0]   status_w;
   logic [NCH-1:0]   mask_w;
   logic             irq_w;

   // bus phases; the access phase always takes one cycle
   assign setup = psel & ~penable;
   assign take  = psel & penable & pready_ff;

   // byte lane 0 carries all register bits; other lanes ignored
   assign wr_en = take & pwrite & pstrb[0] & ~pslverr_ff;

   // address decode shared by the write and read paths
   assign hit_stat = f_hit(paddr, rcr_pkg::IRQ_STATUS_IDX);
   assign hit_mask = f_hit(paddr, rcr_pkg::IRQ_MASK_IDX);
   assign map_hit  = (|hit_vsel) | (|hit_ctrl) | hit_stat | hit_mask;

   // one register slice per channel, shaped by the channel kind
   for (genvar k = 0; k < NCH; k++) begin : g_ch
      assign hit_vsel[k] = f_hit(paddr, rcr_pkg::VSEL_IDX[k]);
      assign hit_ctrl[k] = f_hit(paddr, rcr_pkg::CTRL_IDX[k]);

      rcr_chan #(
         .CODE_W     (rcr_pkg::WIDE_CODE[k] ? rcr_pkg::WIDE_CODE_W
                                            : rcr_pkg::NARROW_CODE_W),
         .HAS_OPT    (rcr_pkg::HAS_PHASE[k] | rcr_pkg::HAS_DISCH[k]),
         .HAS_UNMASK (rcr_pkg::HAS_UNMASK[k])
      ) u_chan (
         .clk       (clk),
         .rst       (rst),
         .vsel_we   (wr_en & hit_vsel[k]),
         .ctrl_we   (wr_en & hit_ctrl[k]),
         .wdata     (pwdata[7:0]),
         .pgood     (power_good[k]),
         .code_ff   (code_w[k]),
         .on_ff     (on_w[k]),
         .opt_ff    (opt_w[k]),
         .unmask_ff (unmask_w[k]),
         .vsel_rd   (vsel_rd[k]),
         .ctrl_rd   (ctrl_rd[k])
      );

      // channels without a mask bit pass faults straight on
      assign evt[k] = channel_fault[k] &
                      (unmask_w[k] | ~rcr_pkg::HAS_UNMASK[k]);
   end

   // fault events latch here and drive the single interrupt line
   rcr_irq #(
      .N (NCH)
   ) u_irq (
      .clk       (clk),
      .rst       (rst),
      .evt       (evt),
      .clr_we    (wr_en & hit_stat),
      .mask_we   (wr_en & hit_mask),
      .wdata     (pwdata[NCH-1:0]),
      .status_ff (status_w),
      .mask_ff   (mask_w),
      .irq_ff    (irq_w)
   );

   // read mux; unmapped words read zero
   always_comb begin
      rd_byte = 8'h00;
      for (int i = 0; i < NCH; i++) begin
         if (hit_vsel[i]) rd_byte = vsel_rd[i];
         if (hit_ctrl[i]) rd_byte = ctrl_rd[i];
      end
      if (hit_stat) rd_byte = 8'(status_w);
      if (hit_mask) rd_byte = 8'(mask_w);
   end

   // ready follows setup, so every transfer has zero wait states
   always_ff @(posedge clk) begin
      if (rst) pready_ff <= 1'h0;
      else pready_ff <= setup;
   end

   // error flag stands during the access cycle of an unmapped word
   always_ff @(posedge clk) begin
      if (rst) pslverr_ff <= 1'h0;
      else pslverr_ff <= setup & ~map_hit;
   end

   // data sampled at setup; registers cannot move under a read
   always_ff @(posedge clk) begin
      if (rst) prdata_ff <= 32'h0000_0000;
      else if (setup & ~pwrite & map_hit) prdata_ff <= {24'h00_0000, rd_byte};
      else prdata_ff <= 32'h0000_0000;
   end

   // outputs, all from flip-flops
   assign prdata                 = prdata_ff;
   assign pready                 = pready_ff;
   assign pslverr                = pslverr_ff;
   assign regulator_on           = on_w;
   assign channel_three_code     = code_w[0][5:0];
   assign channel_four_code      = code_w[1];
   assign channel_five_code      = code_w[2][5:0];
   assign channel_six_code       = code_w[3][5:0];
   assign channel_three_phase    = opt_w[0];
   assign channel_five_discharge = opt_w[2];
   assign channel_six_discharge  = opt_w[3];
   assign irq                    = irq_w;

   // ---- checks kept beside the logic ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_read_setup;
      psel && !penable && !pwrite;
   endsequence

   sequence s_write_done;
      wr_en;
   endsequence

   // access phase answers in one cycle and then drops ready
   property p_apb_ready;
      s_setup |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("ready did not follow setup by one cycle");

   // unmapped word flags an error and reads zero
   property p_apb_unmapped;
      s_setup and !map_hit |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_apb_unmapped: assert property (p_apb_unmapped)
      else $error("unmapped access not flagged");

   property p_code_three;
      s_write_done and hit_vsel[0]
         |=> channel_three_code == $past(pwdata[5:0]);
   endproperty
   a_code_three: assert property (p_code_three)
      else $error("channel three code not stored");

   property p_code_four;
      s_write_done and hit_vsel[1]
         |=> channel_four_code == $past(pwdata[7:0]);
   endproperty
   a_code_four: assert property (p_code_four)
      else $error("channel four code not stored in full");

   // enable written then read back gives the written value
   property p_on_readback;
      (s_write_done and hit_ctrl[2]) ##2 (s_read_setup and hit_ctrl[2])
         |=> prdata[7] == $past(regulator_on[2], 1)
             && prdata[7] == $past(pwdata[7], 3);
   endproperty
   a_on_readback: assert property (p_on_readback)
      else $error("enable bit does not read back");

   property p_on_out;
      s_write_done and hit_ctrl[1] |=> regulator_on[1] == $past(pwdata[7]);
   endproperty
   a_on_out: assert property (p_on_out)
      else $error("enable output does not follow write");

   property p_phase;
      s_write_done and hit_ctrl[0]
         |=> channel_three_phase == $past(pwdata[2]);
   endproperty
   a_phase: assert property (p_phase)
      else $error("phase select not stored");

   property p_fault_pass;
      channel_fault[2] && unmask_w[2] |=> status_w[2];
   endproperty
   a_fault_pass: assert property (p_fault_pass)
      else $error("unmasked fault did not latch");

   property p_fault_block;
      !unmask_w[3] && !status_w[3] |=> !status_w[3];
   endproperty
   a_fault_block: assert property (p_fault_block)
      else $error("masked fault latched");

   property p_pgood_read;
      s_read_setup and hit_ctrl[3] |=> prdata[0] == $past(power_good[3]);
   endproperty
   a_pgood_read: assert property (p_pgood_read)
      else $error("power-good bit wrong on read");

   property p_discharge;
      s_write_done and hit_ctrl[2]
         |=> channel_five_discharge == $past(pwdata[2]);
   endproperty
   a_discharge: assert property (p_discharge)
      else $error("discharge enable not stored");

   property p_four_ctrl;
      s_read_setup and hit_ctrl[1] |=> prdata[6:1] == 6'h00;
   endproperty
   a_four_ctrl: assert property (p_four_ctrl)
      else $error("channel four control reserved bits not zero");

   property p_reserved_code;
      s_read_setup and hit_vsel[2] |=> prdata[31:6] == 26'h000_0000;
   endproperty
   a_reserved_code: assert property (p_reserved_code)
      else $error("reserved code bits not zero");

   property p_ctrl_reserved;
      s_read_setup and hit_ctrl[0] |=> prdata[6:3] == 4'h0;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved)
      else $error("reserved control bits not zero");

   // interrupt line equals the masked status at every edge
   property p_irq_level;
      irq == |(status_w & mask_w);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt does not match masked status");

   // a status clear by software, the step that races a new event
   sequence s_clear_status;
      wr_en && hit_stat;
   endsequence

   // ready only answers a setup cycle
   property p_ready_after_setup;
      pready |-> $past(setup);
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("ready without a preceding setup");

   // read data and error flag only stand together with ready
   property p_idle_bus_quiet;
      !pready |-> prdata == 32'h0000_0000 && !pslverr;
   endproperty
   a_idle_bus_quiet: assert property (p_idle_bus_quiet)
      else $error("read data or error outside the access cycle");

   // a write without the low byte strobe changes no code
   property p_no_strobe;
      take && pwrite && !pstrb[0]
         |=> $stable({channel_three_code, channel_four_code, channel_five_code, channel_six_code});
   endproperty
   a_no_strobe: assert property (p_no_strobe)
      else $error("unstrobed write changed a code");

   property p_code_five;
      s_write_done and hit_vsel[2]
         |=> channel_five_code == $past(pwdata[5:0]);
   endproperty
   a_code_five: assert property (p_code_five)
      else $error("channel five code not stored");

   property p_code_six;
      s_write_done and hit_vsel[3]
         |=> channel_six_code == $past(pwdata[5:0]);
   endproperty
   a_code_six: assert property (p_code_six)
      else $error("channel six code not stored");

   property p_discharge_six;
      s_write_done and hit_ctrl[3]
         |=> channel_six_discharge == $past(pwdata[2]);
   endproperty
   a_discharge_six: assert property (p_discharge_six)
      else $error("channel six discharge enable not stored");

   // channel four has no unmask bit, so its faults always latch
   property p_four_fault;
      channel_fault[1] |=> status_w[1];
   endproperty
   a_four_fault: assert property (p_four_fault)
      else $error("channel four fault did not latch");

   // bits written one drop unless an event of the same cycle re-sets them
   property p_status_clear;
      s_clear_status
         |=> (status_w & $past(pwdata[NCH-1:0] & ~evt)) == '0;
   endproperty
   a_status_clear: assert property (p_status_clear)
      else $error("status bit survived its clear");

   property p_set_wins;
      s_clear_status |=> (status_w & $past(evt)) == $past(evt);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost to a same-cycle clear");

   property p_mask_store;
      s_write_done and hit_mask |=> mask_w == $past(pwdata[NCH-1:0]);
   endproperty
   a_mask_store: assert property (p_mask_store)
      else $error("interrupt mask not stored");
endmodule : rcr_regs
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [9:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  power_good;
   logic [3:0]  channel_fault;
   logic [3:0]  regulator_on;
   logic [5:0]  channel_three_code;
   logic [7:0]  channel_four_code;
   logic [5:0]  channel_five_code;
   logic [5:0]  channel_six_code;
   logic        channel_three_phase;
   logic        channel_five_discharge;
   logic        channel_six_discharge;
   logic        irq;
   int          n_mismatch;
   int          n_checks;
   logic [31:0] seed;
   logic [31:0] rd;
   logic        err;
   logic [31:0] t;
   logic [7:0]  wv [4];
   logic [7:0]  wc [4];

   rcr_regs #(.ADDR_W(10)) rcr_regs_i (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .power_good, .channel_fault, .regulator_on, .channel_three_code, .channel_four_code,
      .channel_five_code, .channel_six_code, .channel_three_phase, .channel_five_discharge,
      .channel_six_discharge, .irq
   );

   // free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // xorshift source, fixed start so runs repeat
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // writable code bits: eight on channel four, six elsewhere
   function automatic logic [7:0] vmask(input int ch);
      return (ch == 1) ? 8'hFF : 8'h3F;
   endfunction : vmask

   // writable control bits: channel four keeps only the enable
   function automatic logic [7:0] cmask(input int ch);
      return (ch == 1) ? 8'h80 : 8'h86;
   endfunction : cmask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // one apb transfer; upper data bits are noise the block must ignore
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] strb,
                      output logic [31:0] q, output logic e);
      logic [31:0] n;
      int          i;
      n = rnd();
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'h0};
      pwdata  <= {n[31:8], d};
      pstrb   <= strb;
      @(posedge clk);
      penable <= 1'b1;
      // look mid-cycle: these are the values the next rising edge samples
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         if (pready === 1'b1) break;
         @(posedge clk);
      end
      if (i == 8) begin
         n_mismatch++;
         $display("ERROR %0t bus transfer never answered", $time);
         finish_test();
      end else begin
         q = prdata;
         e = pslverr;
         @(posedge clk);
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 4'hF, rd, err);
      chk(32'(err), 32'h0, "write error flag");
   endtask : wr

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, idx, 8'h00, 4'h0, rd, err);
      chk(rd, exp, what);
      chk(32'(err), 32'h0, "read error flag");
   endtask : rdchk

   // one-cycle fault pulse on the chosen channels
   task automatic fault(input logic [3:0] v);
      @(posedge clk);
      channel_fault <= v;
      @(posedge clk);
      channel_fault <= 4'h0;
   endtask : fault

   // main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      power_good = 4'h5;
      channel_fault = 4'h0;
      seed = 32'h2FA6;
      n_mismatch = 0;
      n_checks = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // reset state: zero codes, control shows only power-good
      for (int ch = 0; ch < 4; ch++) begin
         rdchk(rcr_pkg::VSEL_IDX[ch], 32'h0, "code after reset");
         rdchk(rcr_pkg::CTRL_IDX[ch], 32'(power_good[ch]), "control after reset");
      end
      // all ones, all zeros, then random; reserved bits go out at their zero default
      for (int k = 0; k < 8; k++) begin
         for (int ch = 0; ch < 4; ch++) begin
            t = rnd();
            wv[ch] = ((k == 0) ? 8'hFF : (k == 1) ? 8'h00 : t[7:0]) & vmask(ch);
            wc[ch] = ((k == 0) ? 8'hFF : (k == 1) ? 8'h00 : t[15:8]) & (cmask(ch) | 8'h01);
            wr(rcr_pkg::VSEL_IDX[ch], wv[ch]);
            rdchk(rcr_pkg::VSEL_IDX[ch], 32'(wv[ch] & vmask(ch)), "code readback");
            // control read follows its own write, so the readback check sees the pair
            power_good <= t[19:16];
            wr(rcr_pkg::CTRL_IDX[ch], wc[ch]);
            rdchk(rcr_pkg::CTRL_IDX[ch], 32'((wc[ch] & cmask(ch)) | t[16 + ch]), "control readback");
         end
         chk(32'(regulator_on), 32'({wc[3][7], wc[2][7], wc[1][7], wc[0][7]}), "enables");
         chk(32'(channel_three_code), 32'(wv[0][5:0]), "code three");
         chk(32'(channel_four_code), 32'(wv[1]), "code four");
         chk(32'({channel_six_code, channel_five_code}), 32'({wv[3][5:0], wv[2][5:0]}), "codes five six");
         chk(32'(channel_three_phase), 32'(wc[0][2]), "phase select");
         chk(32'({channel_six_discharge, channel_five_discharge}), 32'({wc[3][2], wc[2][2]}), "discharge");
      end
      // only enable and live power-good show; the written power-good bit is ignored
      power_good <= 4'hD;
      wr(rcr_pkg::CTRL_IDX[1], 8'h81);
      rdchk(rcr_pkg::CTRL_IDX[1], 32'h80, "channel four control");
      // a write without the low byte strobe is dropped
      apb(1'b1, rcr_pkg::VSEL_IDX[0], ~wv[0] & 8'h3F, 4'h0, rd, err);
      rdchk(rcr_pkg::VSEL_IDX[0], 32'(wv[0] & 8'h3F), "unstrobed write");
      // unmapped index answers with an error and zero data
      apb(1'b0, 8'h31, 8'h00, 4'h0, rd, err);
      chk({rd[31:1], err}, 32'h1, "unmapped read");
      // faults with every unmask bit clear: only channel four may latch
      for (int ch = 0; ch < 4; ch++) wr(rcr_pkg::CTRL_IDX[ch], 8'h00);
      wr(rcr_pkg::IRQ_STATUS_IDX, 8'h0F);
      wr(rcr_pkg::IRQ_MASK_IDX, 8'h0F);
      fault(4'hD);
      rdchk(rcr_pkg::IRQ_STATUS_IDX, 32'h0, "blocked faults");
      chk(32'(irq), 32'h0, "irq while blocked");
      wr(rcr_pkg::CTRL_IDX[0], 8'h02);
      wr(rcr_pkg::CTRL_IDX[2], 8'h02);
      wr(rcr_pkg::CTRL_IDX[3], 8'h02);
      fault(4'hF);
      rdchk(rcr_pkg::IRQ_STATUS_IDX, 32'hF, "passed faults");
      chk(32'(irq), 32'h1, "irq raised");
      wr(rcr_pkg::IRQ_STATUS_IDX, 8'h05);
      rdchk(rcr_pkg::IRQ_STATUS_IDX, 32'hA, "partial clear");
      chk(32'(irq), 32'h1, "irq still pending");
      wr(rcr_pkg::IRQ_MASK_IDX, 8'h05);
      rdchk(rcr_pkg::IRQ_MASK_IDX, 32'h5, "mask readback");
      chk(32'(irq), 32'h0, "irq masked");
      wr(rcr_pkg::IRQ_STATUS_IDX, 8'h0A);
      rdchk(rcr_pkg::IRQ_STATUS_IDX, 32'h0, "status cleared");
      // second reset in mid-run must clear values known to be set
      wr(rcr_pkg::VSEL_IDX[1], 8'hA5);
      wr(rcr_pkg::CTRL_IDX[1], 8'h80);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdchk(rcr_pkg::VSEL_IDX[1], 32'h0, "code after second reset");
      chk(32'(regulator_on), 32'h0, "enables after second reset");
      finish_test();
   end
endmodule : tb
`default_nettype wire
